// *** rtl/ocsc_defs.svh ***
// Constants of the overcurrent and sense configuration block.
// Assumes a 40 MHz system clock; included by the package and modules.
`ifndef OCSC_DEFS_SVH
`define OCSC_DEFS_SVH

// ----------------------------------------
// Register map and reset values
// ----------------------------------------
`define OCSC_ADDR_OCP 4'h5
`define OCSC_ADDR_CSA 4'h6
`define OCSC_RST_OCP 11'h159
`define OCSC_RST_CSA 11'h283
`define OCSC_CSA_SRC_BIT 10
`define OCSC_CSA_LSR_BIT 8

// ----------------------------------------
// Serial frame layout
// ----------------------------------------
`define OCSC_FRM_LAST 5'h0f
`define OCSC_FRM_ADR_END 5'h04
`define OCSC_FRM_DATA_FIRST 5'h05
`define OCSC_FRM_RW 15

// ----------------------------------------
// Timing
// ----------------------------------------
`define OCSC_CLK_MHZ 40
`define OCSC_RETRY_LONG_US 4000
`define OCSC_RETRY_SHORT_US 50
`define OCSC_DEAD_BASE_NS 50
`define OCSC_DEG_STEP_US 2
`define OCSC_RETRY_LONG_CYC (`OCSC_RETRY_LONG_US * `OCSC_CLK_MHZ)
`define OCSC_RETRY_SHORT_CYC (`OCSC_RETRY_SHORT_US * `OCSC_CLK_MHZ)
`define OCSC_DEAD_BASE_CYC ((`OCSC_DEAD_BASE_NS * `OCSC_CLK_MHZ + 999) / 1000)
`define OCSC_DEG_STEP_CYC (`OCSC_DEG_STEP_US * `OCSC_CLK_MHZ)

`endif

// *** rtl/ocsc_pkg.sv ***
// Types and shared decode functions of the configuration block.
// Assumes ocsc_defs.svh is on the include path.
`default_nettype none
`include "ocsc_defs.svh"

package ocsc_pkg;

    // ----------------------------------------
    // Register, state and pin types
    // ----------------------------------------
    typedef enum logic [1:0] {
        OCSC_RESP_LATCH = 2'b00,
        OCSC_RESP_RETRY = 2'b01,
        OCSC_RESP_REPORT = 2'b10,
        OCSC_RESP_OFF = 2'b11
    } ocsc_resp_t;

    typedef enum logic [1:0] {
        OCSC_ST_RUN = 2'b00,
        OCSC_ST_LATCH = 2'b01,
        OCSC_ST_WAIT = 2'b10
    } ocsc_state_t;

    typedef struct packed {
        logic retry_time_select;
        logic [1:0] dead_time_select;
        ocsc_resp_t overcurrent_response_select;
        logic [1:0] overcurrent_filter_time;
        logic [3:0] drain_source_trip_level;
    } ocsc_ocp_t;

    typedef struct packed {
        logic amp_input_source_select;
        logic ref_half_select;
        logic lowside_monitor_return_select;
        logic [1:0] amp_gain_select;
        logic shunt_fault_disable;
        logic amp_a_offset_calibrate;
        logic amp_b_offset_calibrate;
        logic amp_c_offset_calibrate;
        logic [1:0] shunt_trip_level;
    } ocsc_csa_t;

    typedef struct packed {
        logic sclk;
        logic scs_n;
        logic sdi;
        logic ds_oc;
        logic shunt_oc;
        logic [2:0] pwm;
        logic fault_clear;
        logic cycle_clear_on_pwm;
    } ocsc_pins_t;

    // ----------------------------------------
    // Decode functions
    // ----------------------------------------
    function automatic logic [4:0] ocsc_dead_cyc(input logic [1:0] code);
        return 5'(`OCSC_DEAD_BASE_CYC << code);
    endfunction : ocsc_dead_cyc

    function automatic logic [8:0] ocsc_deg_cyc(input logic [1:0] code);
        return 9'(`OCSC_DEG_STEP_CYC * (32'(code) + 1));
    endfunction : ocsc_deg_cyc

endpackage : ocsc_pkg

`default_nettype wire

// *** rtl/ocsc_protect.sv ***
// Overcurrent filter and fault response sequencer.
// Assumes all inputs are already synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
`include "ocsc_defs.svh"

module ocsc_protect
    import ocsc_pkg::*;
#(
    parameter bit HAS_SHUNT = 1'b1,
    parameter logic [17:0] RETRY_LONG_CYC = 18'(`OCSC_RETRY_LONG_CYC)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic ds_oc,
    input wire logic shunt_oc,
    input wire logic pwm_event,
    input wire logic fault_clear,
    input wire logic cbc_en,
    input wire ocsc_ocp_t ocp,
    input wire logic shunt_disable,
    output logic fault_active_ff,
    output logic oc_report_ff
);

    // ----------------------------------------
    // Deglitch filters
    // ----------------------------------------
    logic [8:0] ds_cnt_ff;
    logic [8:0] sh_cnt_ff;
    logic [8:0] deg_lim;
    logic sh_live;
    logic hit;

    function automatic logic [8:0] deg_step(input logic live, input logic [8:0] cnt,
                                            input logic [8:0] lim);
        if (!live) return 9'h000;
        if (cnt < lim) return cnt + 9'h001;
        return cnt;
    endfunction : deg_step

    assign deg_lim = ocsc_deg_cyc(ocp.overcurrent_filter_time);
    assign sh_live = HAS_SHUNT && shunt_oc && !shunt_disable;
    assign hit = (ds_cnt_ff >= deg_lim) || (sh_cnt_ff >= deg_lim);

    always_ff @(posedge clk) begin
        if (rst) begin
            ds_cnt_ff <= 9'h000;
            sh_cnt_ff <= 9'h000;
        end else if (ce) begin
            ds_cnt_ff <= deg_step(ds_oc, ds_cnt_ff, deg_lim);
            sh_cnt_ff <= deg_step(sh_live, sh_cnt_ff, deg_lim);
        end
    end

    // ----------------------------------------
    // Response state machine
    // ----------------------------------------
    ocsc_state_t st_ff;
    ocsc_state_t nxt_st;
    logic [17:0] retry_cnt_ff;
    logic [17:0] retry_lim;
    ocsc_resp_t resp;

    assign resp = ocp.overcurrent_response_select;
    assign retry_lim = ocp.retry_time_select ? 18'(`OCSC_RETRY_SHORT_CYC)
                                             : RETRY_LONG_CYC;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            OCSC_ST_RUN: begin
                if (hit && resp == OCSC_RESP_LATCH) nxt_st = OCSC_ST_LATCH;
                else if (hit && resp == OCSC_RESP_RETRY) nxt_st = OCSC_ST_WAIT;
            end
            OCSC_ST_LATCH: begin
                if (fault_clear && !hit) nxt_st = OCSC_ST_RUN;
            end
            OCSC_ST_WAIT: begin
                if (cbc_en && pwm_event) nxt_st = OCSC_ST_RUN;
                else if (retry_cnt_ff == 18'h00000) nxt_st = OCSC_ST_RUN;
            end
            default: nxt_st = OCSC_ST_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= OCSC_ST_RUN;
            fault_active_ff <= 1'b0;
        end else if (ce) begin
            st_ff <= nxt_st;
            fault_active_ff <= (nxt_st != OCSC_ST_RUN);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            retry_cnt_ff <= 18'h00000;
        end else if (ce) begin
            if (st_ff != OCSC_ST_WAIT) retry_cnt_ff <= retry_lim - 18'h00001;
            else if (retry_cnt_ff != 18'h00000) retry_cnt_ff <= retry_cnt_ff - 18'h00001;
        end
    end

    // The report flag is sticky; a new detection beats a clear in the same cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            oc_report_ff <= 1'b0;
        end else if (ce) begin
            if (hit && resp != OCSC_RESP_OFF) oc_report_ff <= 1'b1;
            else if (fault_clear) oc_report_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_retry_load;
        @(posedge clk) disable iff (rst || !ce)
        st_ff == OCSC_ST_RUN && nxt_st == OCSC_ST_WAIT |=>
            retry_cnt_ff == $past(retry_lim) - 18'h00001;
    endproperty
    a_retry_load: assert property (p_retry_load) else $error("retry load wrong");

    property p_retry_end;
        @(posedge clk) disable iff (rst || !ce)
        st_ff == OCSC_ST_WAIT && retry_cnt_ff == 18'h00000 |=> !fault_active_ff;
    endproperty
    a_retry_end: assert property (p_retry_end) else $error("retry did not end");

    property p_cbc;
        @(posedge clk) disable iff (rst || !ce)
        st_ff == OCSC_ST_WAIT && cbc_en && pwm_event |=> st_ff == OCSC_ST_RUN;
    endproperty
    a_cbc: assert property (p_cbc) else $error("pwm did not clear fault");

    property p_deglitch;
        @(posedge clk) disable iff (rst || !ce)
        $rose(fault_active_ff) |-> $past(hit);
    endproperty
    a_deglitch: assert property (p_deglitch) else $error("fault before filter");

endmodule : ocsc_protect

`default_nettype wire

// *** rtl/ocsc_top.sv ***
// Overcurrent and current-sense configuration registers of a gate driver.
// Assumes the serial pins come from an outside master and are asynchronous.
`timescale 1ns/10ps
`default_nettype none
`include "ocsc_defs.svh"

module ocsc_top
    import ocsc_pkg::*;
#(
    parameter bit HAS_AMP = 1'b1,
    parameter logic [17:0] RETRY_LONG_CYC = 18'(`OCSC_RETRY_LONG_CYC)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic spi_sclk,
    input wire logic spi_scs_n,
    input wire logic spi_sdi,
    input wire logic ds_oc_in,
    input wire logic shunt_oc_in,
    input wire logic [2:0] pwm_in,
    input wire logic fault_clear_in,
    input wire logic cycle_clear_on_pwm,
    output logic spi_sdo_ff,
    output logic spi_sdo_oe_ff,
    output logic [2:0] gate_hs_ff,
    output logic [2:0] gate_ls_ff,
    output logic fault_active_ff,
    output logic oc_report_ff,
    output ocsc_ocp_t ocp_cfg_ff,
    output ocsc_csa_t csa_cfg_ff
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    ocsc_pins_t pins;
    ocsc_pins_t sync1_ff;
    ocsc_pins_t sync2_ff;
    ocsc_pins_t prev_ff;

    assign pins = '{
        sclk: spi_sclk,
        scs_n: spi_scs_n,
        sdi: spi_sdi,
        ds_oc: ds_oc_in,
        shunt_oc: shunt_oc_in,
        pwm: pwm_in,
        fault_clear: fault_clear_in,
        cycle_clear_on_pwm: cycle_clear_on_pwm
    };

    // Idle values keep a reset from looking like a chip-select edge.
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_ff <= '{scs_n: 1'b1, default: '0};
            sync2_ff <= '{scs_n: 1'b1, default: '0};
            prev_ff <= '{scs_n: 1'b1, default: '0};
        end else if (ce) begin
            sync1_ff <= pins;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_act;
    logic cs_start;
    logic pwm_event;
    logic clear_pulse;

    assign sclk_rise = sync2_ff.sclk && !prev_ff.sclk;
    assign sclk_fall = !sync2_ff.sclk && prev_ff.sclk;
    assign cs_act = !sync2_ff.scs_n;
    assign cs_start = cs_act && prev_ff.scs_n;
    assign pwm_event = (sync2_ff.pwm != prev_ff.pwm);
    assign clear_pulse = sync2_ff.fault_clear && !prev_ff.fault_clear;

    // ----------------------------------------
    // Serial frame receiver
    // ----------------------------------------
    // A frame is 16 bits, most significant first: read flag, 4-bit address,
    // 11 data bits. The master changes data on the rising and samples on
    // the falling clock edge. Frames cut short by chip select are dropped.
    logic [15:0] rx_ff;
    logic [4:0] bit_ff;
    logic [3:0] adr_ff;
    logic [15:0] frame;
    logic frame_done;
    logic wr_ocp;
    logic wr_csa;
    logic [10:0] wr_data;

    assign frame = {rx_ff[14:0], sync2_ff.sdi};
    assign frame_done = cs_act && sclk_fall && bit_ff == `OCSC_FRM_LAST;
    assign wr_data = frame[10:0];
    assign wr_ocp = frame_done && !frame[`OCSC_FRM_RW] &&
                    frame[14:11] == `OCSC_ADDR_OCP;
    assign wr_csa = frame_done && !frame[`OCSC_FRM_RW] && HAS_AMP &&
                    frame[14:11] == `OCSC_ADDR_CSA;

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_ff <= 16'h0000;
            bit_ff <= 5'h00;
        end else if (ce) begin
            if (!cs_act) begin
                bit_ff <= 5'h00;
            end else if (sclk_fall && bit_ff <= `OCSC_FRM_LAST) begin
                rx_ff <= frame;
                bit_ff <= bit_ff + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            adr_ff <= 4'h0;
        end else if (ce) begin
            if (cs_act && sclk_fall && bit_ff == `OCSC_FRM_ADR_END) begin
                adr_ff <= frame[3:0];
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ocp_cfg_ff <= ocsc_ocp_t'(`OCSC_RST_OCP);
        end else if (ce) begin
            if (wr_ocp) ocp_cfg_ff <= ocsc_ocp_t'(wr_data);
        end
    end

    logic [10:0] csa_wr;

    // The return-select bit is forced whenever the switch node is chosen.
    always_comb begin
        csa_wr = wr_data;
        if (wr_data[`OCSC_CSA_SRC_BIT]) csa_wr[`OCSC_CSA_LSR_BIT] = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            csa_cfg_ff <= ocsc_csa_t'(`OCSC_RST_CSA);
        end else if (ce) begin
            // Fields drive the analog sense path directly.
            // Gain, calibration and shunt level follow.
            if (wr_csa) csa_cfg_ff <= ocsc_csa_t'(csa_wr);
        end
    end

    // ----------------------------------------
    // Read-back
    // ----------------------------------------
    logic [10:0] rd_data;

    always_comb begin
        rd_data = 11'h000;
        if (adr_ff == `OCSC_ADDR_OCP) rd_data = ocp_cfg_ff;
        else if (adr_ff == `OCSC_ADDR_CSA && HAS_AMP) rd_data = csa_cfg_ff;
    end

    // The output follows the sampled clock, so the master must leave at least
    // four system clocks between serial clock edges.
    always_ff @(posedge clk) begin
        if (rst) begin
            spi_sdo_ff <= 1'b0;
            spi_sdo_oe_ff <= 1'b0;
        end else if (ce) begin
            spi_sdo_oe_ff <= cs_act;
            if (cs_start) begin
                spi_sdo_ff <= 1'b0;
            end else if (cs_act && sclk_rise) begin
                if (bit_ff >= `OCSC_FRM_DATA_FIRST && bit_ff <= `OCSC_FRM_LAST) begin
                    spi_sdo_ff <= rd_data[4'(5'h0f - bit_ff)];
                end else begin
                    spi_sdo_ff <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Fault response
    // ----------------------------------------
    ocsc_protect #(
        .HAS_SHUNT(HAS_AMP),
        .RETRY_LONG_CYC(RETRY_LONG_CYC)
    ) u_protect (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .ds_oc(sync2_ff.ds_oc),
        .shunt_oc(sync2_ff.shunt_oc),
        .pwm_event(pwm_event),
        .fault_clear(clear_pulse),
        .cbc_en(sync2_ff.cycle_clear_on_pwm),
        .ocp(ocp_cfg_ff),
        .shunt_disable(csa_cfg_ff.shunt_fault_disable),
        .fault_active_ff(fault_active_ff),
        .oc_report_ff(oc_report_ff)
    );

    // ----------------------------------------
    // Gate outputs with dead time
    // ----------------------------------------
    // Each phase has one complementary input. On every change both switches
    // are turned off, and the new one waits out the dead time; the real gap
    // is one clock longer than the programmed figure, which errs safe.
    logic [2:0][4:0] dt_cnt_ff;
    logic [4:0] dt_lim;

    assign dt_lim = ocsc_dead_cyc(ocp_cfg_ff.dead_time_select);

    always_ff @(posedge clk) begin
        if (rst) begin
            gate_hs_ff <= 3'h0;
            gate_ls_ff <= 3'h0;
            dt_cnt_ff <= '0;
        end else if (ce) begin
            for (int i = 0; i < 3; i++) begin
                if (fault_active_ff || sync2_ff.pwm[i] != prev_ff.pwm[i]) begin
                    gate_hs_ff[i] <= 1'b0;
                    gate_ls_ff[i] <= 1'b0;
                    dt_cnt_ff[i] <= dt_lim;
                end else if (dt_cnt_ff[i] != 5'h00) begin
                    dt_cnt_ff[i] <= dt_cnt_ff[i] - 5'h01;
                end else begin
                    gate_hs_ff[i] <= prev_ff.pwm[i];
                    gate_ls_ff[i] <= !prev_ff.pwm[i];
                end
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking

    default disable iff (rst || !ce);

    property p_no_overlap;
        (gate_hs_ff & gate_ls_ff) == 3'h0;
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both gates on");

    sequence s_hs_off;
        $fell(gate_hs_ff[0]);
    endsequence

    sequence s_ls_hold;
        !gate_ls_ff[0] [*2];
    endsequence

    property p_dead_gap;
        s_hs_off |-> s_ls_hold;
    endproperty
    a_dead_gap: assert property (p_dead_gap) else $error("dead gap too short");

    property p_dead_load;
        !fault_active_ff && sync2_ff.pwm[1] != prev_ff.pwm[1] |=>
            dt_cnt_ff[1] == $past(dt_lim);
    endproperty
    a_dead_load: assert property (p_dead_load) else $error("dead time not loaded");

    property p_src_forces_ref;
        csa_cfg_ff.amp_input_source_select |-> csa_cfg_ff.lowside_monitor_return_select;
    endproperty
    a_src_forces_ref: assert property (p_src_forces_ref) else $error("ref not forced");

    property p_fault_blocks;
        fault_active_ff |=> gate_hs_ff == 3'h0 && gate_ls_ff == 3'h0;
    endproperty
    a_fault_blocks: assert property (p_fault_blocks) else $error("gate on in fault");

    property p_report_only;
        ocp_cfg_ff.overcurrent_response_select[1] && !fault_active_ff |=> !fault_active_ff;
    endproperty
    a_report_only: assert property (p_report_only) else $error("report mode acted");

    property p_silent;
        ocp_cfg_ff.overcurrent_response_select == OCSC_RESP_OFF && !oc_report_ff
            && !wr_ocp |=> !oc_report_ff;
    endproperty
    a_silent: assert property (p_silent) else $error("off mode reported");

    property p_write_ocp;
        wr_ocp |=> ocp_cfg_ff == ocsc_ocp_t'($past(wr_data));
    endproperty
    a_write_ocp: assert property (p_write_ocp) else $error("write not stored");

    property p_write_csa;
        wr_csa |=> csa_cfg_ff == ocsc_csa_t'($past(csa_wr));
    endproperty
    a_write_csa: assert property (p_write_csa) else $error("sense write not stored");

    property p_no_reg;
        adr_ff != `OCSC_ADDR_OCP && adr_ff != `OCSC_ADDR_CSA |-> rd_data == 11'h000;
    endproperty
    a_no_reg: assert property (p_no_reg) else $error("stray read data");

    property p_gate_follow;
        !fault_active_ff && dt_cnt_ff[2] == 5'h00 && sync2_ff.pwm[2] == prev_ff.pwm[2] |=>
            gate_hs_ff[2] == $past(prev_ff.pwm[2]) && gate_ls_ff[2] != $past(prev_ff.pwm[2]);
    endproperty
    a_gate_follow: assert property (p_gate_follow) else $error("gate not on after gap");

    property p_no_csa;
        !HAS_AMP |-> csa_cfg_ff == ocsc_csa_t'(`OCSC_RST_CSA);
    endproperty
    a_no_csa: assert property (p_no_csa) else $error("absent register written");

    property p_sdo_idle;
        !cs_act |=> !spi_sdo_oe_ff;
    endproperty
    a_sdo_idle: assert property (p_sdo_idle) else $error("sdo driven while idle");

endmodule : ocsc_top

`default_nettype wire

// *** verification/ocsc_top_tb.sv ***
// Self-checking bench for the overcurrent and sense configuration block.
// Assumes ocsc_pkg and ocsc_top are compiled before it.
`timescale 1ns/10ps
`default_nettype none

module ocsc_top_tb;
    import ocsc_pkg::*;

    logic clk, rst, ce, sclk, scs_n, sdi, ds_oc, sh_oc, fclr, cbc;
    logic [2:0] pwm;
    logic sdo, sdo_oe, flt, rep;
    logic [2:0] ghs, gls;
    ocsc_ocp_t ocp;
    ocsc_csa_t csa;
    logic rep2;
    ocsc_csa_t csa2;
    int mismatches;
    int checked;

    // --------------------------------
    // Device and helpers
    // --------------------------------
    // The long retry count is cut to 200 clocks so both retry codes fit the run.
    ocsc_top #(.RETRY_LONG_CYC(18'h000c8)) dut (.clk(clk), .rst(rst), .ce(ce),
        .spi_sclk(sclk), .spi_scs_n(scs_n), .spi_sdi(sdi), .ds_oc_in(ds_oc),
        .shunt_oc_in(sh_oc), .pwm_in(pwm), .fault_clear_in(fclr),
        .cycle_clear_on_pwm(cbc), .spi_sdo_ff(sdo), .spi_sdo_oe_ff(sdo_oe),
        .gate_hs_ff(ghs), .gate_ls_ff(gls), .fault_active_ff(flt),
        .oc_report_ff(rep), .ocp_cfg_ff(ocp), .csa_cfg_ff(csa));

    // The variant without sense amplifiers shares every input of the first one.
    ocsc_top #(.HAS_AMP(1'b0), .RETRY_LONG_CYC(18'h000c8)) dut_noamp (.clk(clk), .rst(rst),
        .ce(ce), .spi_sclk(sclk), .spi_scs_n(scs_n), .spi_sdi(sdi), .ds_oc_in(ds_oc),
        .shunt_oc_in(sh_oc), .pwm_in(pwm), .fault_clear_in(fclr),
        .cycle_clear_on_pwm(cbc), .spi_sdo_ff(), .spi_sdo_oe_ff(), .gate_hs_ff(),
        .gate_ls_ff(), .fault_active_ff(), .oc_report_ff(rep2), .ocp_cfg_ff(),
        .csa_cfg_ff(csa2));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    task automatic cmp(input string nm, input logic [10:0] e, input logic [10:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic rng(input string nm, input int lo, input int hi, input int g);
        checked++;
        if (g < lo || g > hi) begin
            mismatches++;
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : rng

    // Waits on the fault flag (sel 0) or the report flag (sel 1).
    task automatic waitfor(input int sel, input logic v, input int lim, output int n);
        n = 0;
        while ((sel != 0 ? rep : flt) !== v) begin
            if (n == lim) begin
                mismatches++;
                $display("BAD wait %0d expected %b seen timeout", sel, v);
                end_of_test();
            end
            tick(1);
            n++;
        end
    endtask : waitfor

    // Six clocks per half period leave room for the two-flop pin sync.
    task automatic frame(input logic rw, input logic [3:0] a, input logic [10:0] d,
        output logic [10:0] q);
        logic [15:0] w;
        w = {rw, a, d};
        q = 11'h000;
        scs_n = 1'b0;
        tick(6);
        for (int i = 15; i >= 0; i--) begin
            sdi = w[i];
            sclk = 1'b1;
            tick(6);
            if (i < 11) q[i] = sdo;
            if (i == 0) cmp("sdo oe", 11'h001, {10'h000, sdo_oe});
            sclk = 1'b0;
            tick(6);
        end
        scs_n = 1'b1;
        tick(6);
    endtask : frame

    task automatic clr();
        fclr = 1'b1;
        tick(4);
        fclr = 1'b0;
        tick(4);
    endtask : clr

    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_regs();
        logic [10:0] q;
        cmp("ocp reset", 11'h159, ocp);
        frame(1'b1, 4'h5, 11'h000, q);
        cmp("ocp read", 11'h159, q);
        frame(1'b1, 4'h6, 11'h000, q);
        cmp("csa read", 11'h283, q);
        frame(1'b0, 4'h5, 11'h2aa, q);
        cmp("ocp write", 11'h2aa, ocp);
        frame(1'b0, 4'h6, 11'h2ff, q);
        frame(1'b1, 4'h6, 11'h000, q);
        cmp("csa fields", 11'h2ff, q);
        cmp("csa absent", 11'h283, csa2);
        frame(1'b0, 4'h6, 11'h400, q);
        cmp("csa forced", 11'h500, csa);
        frame(1'b0, 4'h7, 11'h7ff, q);
        frame(1'b1, 4'h7, 11'h000, q);
        cmp("unmapped", 11'h000, q);
        cmp("ocp kept", 11'h2aa, ocp);
        frame(1'b0, 4'h6, 11'h283, q);
        $display("test regs done");
    endtask : t_regs

    task automatic t_latch();
        logic [10:0] q;
        int n;
        for (int c = 0; c < 4; c++) begin
            frame(1'b0, 4'h5, {3'b001, 2'b00, 2'(c), 4'h9}, q);
            ds_oc = 1'b1;
            waitfor(0, 1'b1, 400, n);
            rng("deglitch", 80 * (c + 1), 80 * (c + 1) + 5, n);
            tick(2);
            cmp("gates off", 11'h000, {5'h00, ghs, gls});
            clr();
            cmp("latched", 11'h001, {10'h000, flt});
            ds_oc = 1'b0;
            tick(4);
            clr();
            cmp("cleared", 11'h000, {9'h000, flt, rep});
        end
        $display("test latch done");
    endtask : t_latch

    task automatic t_retry();
        logic [10:0] q;
        int n;
        for (int b = 0; b < 2; b++) begin
            frame(1'b0, 4'h5, {1'(b), 2'b01, 2'b01, 2'b00, 4'h9}, q);
            ds_oc = 1'b1;
            waitfor(0, 1'b1, 200, n);
            ds_oc = 1'b0;
            waitfor(0, 1'b0, 2100, n);
            rng("retry", b ? 1999 : 199, b ? 2001 : 201, n);
            clr();
        end
        cbc = 1'b1;
        ds_oc = 1'b1;
        waitfor(0, 1'b1, 200, n);
        ds_oc = 1'b0;
        tick(20);
        pwm[1] = ~pwm[1];
        waitfor(0, 1'b0, 10, n);
        rng("pwm clear", 0, 8, n);
        cbc = 1'b0;
        clr();
        $display("test retry done");
    endtask : t_retry

    task automatic t_report();
        logic [10:0] q;
        int n;
        frame(1'b0, 4'h5, 11'h199, q);
        ds_oc = 1'b1;
        waitfor(1, 1'b1, 400, n);
        cmp("report only", 11'h000, {10'h000, flt});
        ds_oc = 1'b0;
        tick(4);
        clr();
        frame(1'b0, 4'h5, 11'h1d9, q);
        ds_oc = 1'b1;
        tick(400);
        cmp("silent", 11'h000, {9'h000, flt, rep});
        ds_oc = 1'b0;
        frame(1'b0, 4'h5, 11'h199, q);
        frame(1'b0, 4'h6, 11'h2a3, q);
        sh_oc = 1'b1;
        tick(400);
        cmp("shunt off", 11'h000, {10'h000, rep});
        frame(1'b0, 4'h6, 11'h283, q);
        waitfor(1, 1'b1, 400, n);
        cmp("no amp shunt", 11'h000, {10'h000, rep2});
        sh_oc = 1'b0;
        tick(4);
        clr();
        $display("test report done");
    endtask : t_report

    task automatic t_dead();
        logic [10:0] q;
        int n;
        int m;
        for (int c = 0; c < 4; c++) begin
            frame(1'b0, 4'h5, {1'b0, 2'(c), 2'b11, 2'b01, 4'h9}, q);
            pwm[0] = ~pwm[0];
            n = 0;
            m = 0;
            while ((pwm[0] ? ghs[0] : gls[0]) !== 1'b1 && n < 60) begin
                if (ghs[0] === 1'b0 && gls[0] === 1'b0) m++;
                if (ghs[0] === 1'b1 && gls[0] === 1'b1) m = 99;
                tick(1);
                n++;
            end
            rng("dead gap", (2 << c), (2 << c) + 2, m);
            if (n >= 60) begin
                cmp("dead wait", 11'h001, 11'h000);
                end_of_test();
            end
        end
        ce = 1'b0;
        pwm[2] = ~pwm[2];
        tick(10);
        cmp("ce freeze", 11'h001, {9'h000, ghs[2], gls[2]});
        ce = 1'b1;
        $display("test dead done");
    endtask : t_dead

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        mismatches = 0;
        checked = 0;
        rst = 1'b1;
        ce = 1'b1;
        sclk = 1'b0;
        scs_n = 1'b1;
        sdi = 1'b0;
        ds_oc = 1'b0;
        sh_oc = 1'b0;
        fclr = 1'b0;
        cbc = 1'b0;
        pwm = 3'h0;
        tick(8);
        rst = 1'b0;
        tick(2);
        t_regs();
        t_latch();
        t_retry();
        t_report();
        t_dead();
        end_of_test();
    end
endmodule : ocsc_top_tb

`default_nettype wire
